// ### common/sec_pkg.sv
// Constants and types for the per-hart state-enable register bank
`default_nettype none

package sec_pkg;

  // ****************************************************************
  // Configuration
  // ****************************************************************
  localparam int          NUM_REGS    = 4;
  localparam int          REG_W       = 64;
  localparam int          HALF_W      = 32;
  localparam logic        HAS_SUPER   = 1'b1;
  localparam logic        HAS_HYPER   = 1'b1;
  localparam int          GATE_BIT    = 63;

  // ****************************************************************
  // Field masks: writable bits and bits fixed at one, per register
  // ****************************************************************
  localparam logic [3:0][63:0] M_WR_MASK  = {64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000,
                                             64'h8000_0000_0000_0000, 64'hC000_0000_0000_0007};
  localparam logic [3:0][63:0] M_ONE_MASK = {4{64'h0000_0000_0000_0000}};
  localparam logic [3:0][63:0] H_WR_MASK  = {64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000,
                                             64'h8000_0000_0000_0000, 64'hC000_0000_0000_0007};
  localparam logic [3:0][63:0] H_ONE_MASK = {4{64'h0000_0000_0000_0000}};
  // Upper half never writable at supervisor level
  localparam logic [3:0][63:0] S_WR_MASK  = {64'h0000_0000_0000_0000, 64'h0000_0000_0000_0000,
                                             64'h0000_0000_0000_0000, 64'h0000_0000_0000_0007};
  localparam logic [3:0][63:0] S_ONE_MASK = {4{64'h0000_0000_0000_0000}};
  localparam logic [63:0]      UPPER_MASK = 64'hFFFF_FFFF_0000_0000;
  localparam logic [63:0]      RESET_VAL  = 64'h0000_0000_0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    SEC_PRIV_U  = 3'h0,
    SEC_PRIV_S  = 3'h1,
    SEC_PRIV_M  = 3'h3,
    SEC_PRIV_VU = 3'h4,
    SEC_PRIV_VS = 3'h5
  } sec_priv_t;

  typedef enum logic [1:0] {
    SEC_LVL_M = 2'h0,
    SEC_LVL_H = 2'h1,
    SEC_LVL_S = 2'h2
  } sec_level_t;

endpackage : sec_pkg

`default_nettype wire

// ### verilog/sec_state_enable.sv
// State-enable register bank with access and state-gating checks
`default_nettype none

module sec_state_enable #(
  parameter bit HART_XLEN32 = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [2:0]  priv_mode,
  input  wire logic        csr_req,
  input  wire logic        csr_write,
  input  wire logic [1:0]  csr_level,
  input  wire logic [1:0]  csr_index,
  input  wire logic        csr_upper,
  input  wire logic [63:0] csr_wdata,
  output logic             csr_rsp_valid,
  output logic [63:0]      csr_rdata,
  output logic             csr_illegal,
  output logic             csr_virtual,
  input  wire logic        chk_req,
  input  wire logic [1:0]  chk_index,
  input  wire logic [5:0]  chk_bit,
  output logic             chk_illegal,
  output logic             chk_virtual
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [63:0] sec_merge(input logic [63:0] old_v, input logic [63:0] wd,
                                            input logic [63:0] mask, input logic upper);
    logic [63:0] data;
    logic [63:0] lane;
    data = wd;
    lane = 64'hFFFF_FFFF_FFFF_FFFF;
    if (HART_XLEN32) begin
      data = upper ? {wd[31:0], 32'h0000_0000} : {32'h0000_0000, wd[31:0]};
      lane = upper ? sec_pkg::UPPER_MASK : ~sec_pkg::UPPER_MASK;
    end
    sec_merge = (old_v & ~(mask & lane)) | (data & mask & lane);
  endfunction : sec_merge

  function automatic logic [63:0] sec_view(input logic [63:0] v, input logic upper);
    sec_view = v;
    if (HART_XLEN32) begin
      sec_view = {32'h0000_0000, upper ? v[63:32] : v[31:0]};
    end
  endfunction : sec_view

  // ****************************************************************
  // Storage and effective values
  // ****************************************************************
  logic [63:0] m_reg [4];
  logic [63:0] h_reg [4];
  logic [63:0] s_reg [4];
  logic [63:0] m_eff [4];
  logic [63:0] h_eff [4];
  logic [63:0] s_hs  [4];
  logic [63:0] s_vs  [4];

  // Fixed-one bits below machine level only survive where the level above is one,
  // so a mis-set mask cannot break the cascade
  for (genvar i = 0; i < sec_pkg::NUM_REGS; i++) begin : g_eff
    assign m_eff[i] = (m_reg[i] & sec_pkg::M_WR_MASK[i]) | sec_pkg::M_ONE_MASK[i];
    assign h_eff[i] = sec_pkg::HAS_HYPER ?
                      (((h_reg[i] & sec_pkg::H_WR_MASK[i]) | sec_pkg::H_ONE_MASK[i]) & m_eff[i]) :
                      64'h0000_0000_0000_0000;
    assign s_hs[i]  = sec_pkg::HAS_SUPER ?
                      (((s_reg[i] & sec_pkg::S_WR_MASK[i]) | sec_pkg::S_ONE_MASK[i]) & m_eff[i]
                       & ~sec_pkg::UPPER_MASK) : 64'h0000_0000_0000_0000;
    assign s_vs[i]  = sec_pkg::HAS_HYPER ? (s_hs[i] & h_eff[i]) : s_hs[i];
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire is_m    = priv_mode == sec_pkg::SEC_PRIV_M;
  wire is_hs   = priv_mode == sec_pkg::SEC_PRIV_S;
  wire is_u    = priv_mode == sec_pkg::SEC_PRIV_U;
  wire is_vs   = priv_mode == sec_pkg::SEC_PRIV_VS;
  wire is_vu   = priv_mode == sec_pkg::SEC_PRIV_VU;
  wire is_virt = is_vs | is_vu;

  // ****************************************************************
  // Register access decision
  // ****************************************************************
  wire lvl_m  = csr_level == sec_pkg::SEC_LVL_M;
  wire lvl_h  = csr_level == sec_pkg::SEC_LVL_H;
  wire lvl_s  = csr_level == sec_pkg::SEC_LVL_S;
  wire m_gate = m_eff[csr_index][sec_pkg::GATE_BIT];
  wire h_gate = h_eff[csr_index][sec_pkg::GATE_BIT];
  // Upper halves exist only on a 32-bit hart, and never at supervisor level
  wire bad_half = csr_upper & (~HART_XLEN32 | lvl_s);

  // Machine mode always passes; each gate bit only limits modes below the level that owns it
  wire m_ok   = is_m;
  wire h_ok   = sec_pkg::HAS_HYPER & (is_m | (is_hs & m_gate));
  wire h_virt = sec_pkg::HAS_HYPER & is_virt & m_gate;
  wire s_ok   = sec_pkg::HAS_SUPER & (is_m | (is_hs & m_gate) |
                (is_vs & m_gate & (h_gate | ~sec_pkg::HAS_HYPER)));
  wire s_virt = sec_pkg::HAS_SUPER & ((is_vs & m_gate & sec_pkg::HAS_HYPER & ~h_gate) | is_vu);

  wire acc_ok   = ~bad_half & ((lvl_m & m_ok) | (lvl_h & h_ok) | (lvl_s & s_ok));
  wire acc_virt = ~bad_half & ~acc_ok & ((lvl_h & h_virt) | (lvl_s & s_virt));
  wire acc_wr   = csr_req & csr_write & acc_ok;

  wire [63:0] view_sel = lvl_m ? m_eff[csr_index] :
                         lvl_h ? h_eff[csr_index] :
                         is_virt ? s_vs[csr_index] : s_hs[csr_index];
  // Writable bits below machine level follow the live cascade
  wire [63:0] h_wmask  = sec_pkg::H_WR_MASK[csr_index] & m_eff[csr_index];
  wire [63:0] s_wmask  = sec_pkg::S_WR_MASK[csr_index] & m_eff[csr_index] &
                         ((is_virt & sec_pkg::HAS_HYPER) ? h_eff[csr_index] : 64'hFFFF_FFFF_FFFF_FFFF);

  // ****************************************************************
  // Register update
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < sec_pkg::NUM_REGS; i++) begin
      if (srst) begin
        m_reg[i] <= sec_pkg::RESET_VAL;
        h_reg[i] <= sec_pkg::RESET_VAL;
        s_reg[i] <= sec_pkg::RESET_VAL;
      end else if (acc_wr && csr_index == i[1:0]) begin
        if (lvl_m) m_reg[i] <= sec_merge(m_reg[i], csr_wdata, sec_pkg::M_WR_MASK[i], csr_upper);
        if (lvl_h) h_reg[i] <= sec_merge(h_reg[i], csr_wdata, h_wmask, csr_upper);
        if (lvl_s) s_reg[i] <= sec_merge(s_reg[i], csr_wdata, s_wmask, csr_upper);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      csr_rsp_valid <= 1'b0;
      csr_rdata     <= 64'h0000_0000_0000_0000;
      csr_illegal   <= 1'b0;
      csr_virtual   <= 1'b0;
    end else begin
      csr_rsp_valid <= csr_req;
      csr_rdata     <= (csr_req & acc_ok) ? sec_view(view_sel, csr_upper) : 64'h0000_0000_0000_0000;
      csr_illegal   <= csr_req & ~acc_ok & ~acc_virt;
      csr_virtual   <= csr_req & acc_virt;
    end
  end

  // ****************************************************************
  // Extension state gating
  // ****************************************************************
  wire chk_m  = m_eff[chk_index][chk_bit];
  wire chk_h  = h_eff[chk_index][chk_bit] | ~sec_pkg::HAS_HYPER;
  wire chk_su = s_hs[chk_index][chk_bit];
  wire chk_sv = s_vs[chk_index][chk_bit];

  // Machine mode is never gated; user mode needs both machine and supervisor bits
  assign chk_illegal = chk_req & ~is_m & (~chk_m | (is_u & ~chk_su));
  assign chk_virtual = chk_req & chk_m & ((is_vs & ~chk_h) | (is_vu & (~chk_h | ~chk_sv)));

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic cascade_bad;
  always_comb begin
    cascade_bad = 1'b0;
    for (int i = 0; i < sec_pkg::NUM_REGS; i++) begin
      cascade_bad = cascade_bad | (|(h_eff[i] & ~m_eff[i])) | (|(s_hs[i] & ~m_eff[i]))
                    | (|(s_vs[i] & ~h_eff[i] & {64{sec_pkg::HAS_HYPER}}));
    end
  end

  m_reset_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    $past(srst) |-> (m_eff[0] == sec_pkg::M_ONE_MASK[0]) && (m_eff[3] == sec_pkg::M_ONE_MASK[3]))
    else $error("machine enable not cleared by reset");

  zero_cascade_a: assert property (!cascade_bad)
    else $error("lower enable bit set above a zero bit");

  s_upper_zero_a: assert property ((s_hs[0] & sec_pkg::UPPER_MASK) == 64'h0 &&
                                   (s_hs[1] & sec_pkg::UPPER_MASK) == 64'h0)
    else $error("supervisor upper bit not zero");

  rsp_timing_a: assert property (csr_req |=> csr_rsp_valid ##1 (!csr_rsp_valid || $past(csr_req)))
    else $error("response not one cycle after request");

  m_from_low_a: assert property (csr_req && lvl_m && !is_m |=> csr_rsp_valid && csr_illegal && !csr_virtual)
    else $error("machine register reachable below machine mode");

  gate_bit_a: assert property (csr_req && lvl_h && is_hs && !m_gate |=> csr_illegal)
    else $error("hypervisor register open with gate bit clear");

  vs_gate_a: assert property (csr_req && lvl_s && is_vs && m_gate && !h_gate && !csr_upper |=> csr_virtual)
    else $error("supervisor register open to virtual mode with gate clear");

  h_gate_wr_a: assert property (csr_req && csr_write && lvl_h && is_m && !csr_upper && !HART_XLEN32
                                && csr_index == 2'h0 && m_eff[0][63]
                                |=> h_eff[0][63] == $past(csr_wdata[63]))
    else $error("hypervisor gate bit not writable");

  own_level_a: assert property (chk_req && is_m |-> !chk_illegal && !chk_virtual)
    else $error("machine mode gated by its own enables");

  virt_trap_a: assert property (chk_req && is_vs && chk_m && !chk_h |-> chk_virtual && !chk_illegal)
    else $error("virtual supervisor block not a virtual trap");

  user_trap_a: assert property (chk_req && is_u && !chk_su |-> chk_illegal)
    else $error("user access not blocked by supervisor bit");

  vs_read_a: assert property (csr_req && lvl_s && is_vs && !csr_write && !HART_XLEN32
                              |=> (csr_rdata & ~$past(h_eff[csr_index])) == 64'h0)
    else $error("virtual supervisor read shows bit zero above");

  // A blocked state check must pick exactly one kind of trap
  chk_one_trap_a: assert property (!(chk_illegal && chk_virtual))
    else $error("state check raised both trap kinds");
  vu_super_virt_a: assert property (csr_req && lvl_s && is_vu && !csr_upper |=> csr_virtual)
    else $error("supervisor register not virtual trap from virtual user");

  m_write_c: cover property (csr_req && csr_write && lvl_m && is_m ##1 csr_rsp_valid && !csr_illegal);
  vs_virtual_c: cover property (csr_req && lvl_s && is_vs ##1 csr_virtual);
  chk_block_c: cover property (chk_req && is_vu && chk_virtual);
  user_ok_c: cover property (chk_req && is_u && !chk_illegal);

endmodule : sec_state_enable

`default_nettype wire

// ### sim/sec_pipe_model.sv
// Decode-side model that issues enable-register accesses and collects the answers
`default_nettype none

module sec_pipe_model (
  input  wire logic        clk_sys,
  output logic [2:0]       priv_mode,
  output logic             csr_req,
  output logic             csr_write,
  output logic [1:0]       csr_level,
  output logic [1:0]       csr_index,
  output logic             csr_upper,
  output logic [63:0]      csr_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [63:0] rdata,
  input  wire logic        rsp_ill,
  input  wire logic        rsp_vir
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {priv_mode, csr_req, csr_write, csr_level, csr_index, csr_upper} = 10'h0;
    csr_wdata = 64'h0;
  end

  task automatic set_mode(input logic [2:0] md);
    priv_mode = md;
  endtask : set_mode

  // One access: request stands one cycle, answer is taken in the following cycle
  task automatic acc(input logic [2:0] md, input logic wr, input logic [1:0] lv, input logic [1:0] ix,
                     input logic up, input logic [63:0] wd, output logic [63:0] rd, output logic [2:0] st);
    @(negedge clk_sys);
    {priv_mode, csr_req, csr_write, csr_level, csr_index, csr_upper} = {md, 1'b1, wr, lv, ix, up};
    csr_wdata = wd;
    @(negedge clk_sys);
    rd = rdata;
    st = {rsp_valid, rsp_ill, rsp_vir};
    csr_req = 1'b0;
    // Idle data is inverted so a stale value never passes for live write data
    csr_wdata = ~wd;
  endtask : acc
endmodule : sec_pipe_model

`default_nettype wire

// ### sim/sec_state_enable_tb.sv
// Self-checking bench for the state-enable register bank
`default_nettype none

module sec_state_enable_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [2:0]  PU = sec_pkg::SEC_PRIV_U;
  localparam logic [2:0]  PS = sec_pkg::SEC_PRIV_S;
  localparam logic [2:0]  PM = sec_pkg::SEC_PRIV_M;
  localparam logic [2:0]  PVU = sec_pkg::SEC_PRIV_VU;
  localparam logic [2:0]  PVS = sec_pkg::SEC_PRIV_VS;
  localparam logic [1:0]  LM = sec_pkg::SEC_LVL_M;
  localparam logic [1:0]  LH = sec_pkg::SEC_LVL_H;
  localparam logic [1:0]  LS = sec_pkg::SEC_LVL_S;
  localparam logic [1:0]  IL = 2'h2;
  localparam logic [1:0]  VI = 2'h1;
  localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] F0 = 64'hC000_0000_0000_0007;

  logic        clk_sys, srst, csr_req, csr_write, csr_upper;
  logic [2:0]  priv_mode;
  logic [1:0]  csr_level, csr_index, chk_index;
  logic [63:0] csr_wdata, csr_rdata;
  logic        csr_rsp_valid, csr_illegal, csr_virtual;
  logic        chk_req, chk_illegal, chk_virtual;
  logic [5:0]  chk_bit;
  int          n_mismatch;
  int          n_compared;

  sec_state_enable DUT (.clk_sys(clk_sys), .srst(srst), .priv_mode(priv_mode), .csr_req(csr_req),
    .csr_write(csr_write), .csr_level(csr_level), .csr_index(csr_index), .csr_upper(csr_upper),
    .csr_wdata(csr_wdata), .csr_rsp_valid(csr_rsp_valid), .csr_rdata(csr_rdata), .csr_illegal(csr_illegal),
    .csr_virtual(csr_virtual), .chk_req(chk_req), .chk_index(chk_index), .chk_bit(chk_bit),
    .chk_illegal(chk_illegal), .chk_virtual(chk_virtual));

  sec_pipe_model pm (.clk_sys(clk_sys), .priv_mode(priv_mode), .csr_req(csr_req), .csr_write(csr_write),
    .csr_level(csr_level), .csr_index(csr_index), .csr_upper(csr_upper), .csr_wdata(csr_wdata),
    .rsp_valid(csr_rsp_valid), .rdata(csr_rdata), .rsp_ill(csr_illegal), .rsp_vir(csr_virtual));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ********************************
  // Shared checks
  // ********************************
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic xa(input logic [2:0] md, input logic wr, input logic [1:0] lv, input logic [1:0] ix,
                    input logic [63:0] wd, input logic [63:0] erd, input logic [1:0] et, input logic up = 1'b0);
    logic [63:0] rd;
    logic [2:0]  st;
    pm.acc(md, wr, lv, ix, up, wd, rd, st);
    cmp("csr_response", {61'h0, 1'b1, et}, {61'h0, st});
    cmp("csr_rdata", erd, rd);
  endtask : xa

  task automatic ck(input logic [2:0] md, input logic [1:0] ix, input logic [5:0] bt, input logic [1:0] et);
    @(negedge clk_sys);
    pm.set_mode(md);
    {chk_req, chk_index, chk_bit} = {1'b1, ix, bt};
    #5;
    cmp("chk_trap", {62'h0, et}, {62'h0, chk_illegal, chk_virtual});
    chk_req = 1'b0;
  endtask : ck

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset();
    for (int i = 0; i < 4; i++) xa(PM, 1'b0, LM, i[1:0], ONES, 64'h0, 2'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_mwrite();
    for (int i = 0; i < 4; i++) begin
      xa(PM, 1'b1, LM, i[1:0], ONES, 64'h0, 2'h0);
      xa(PM, 1'b0, LM, i[1:0], 64'h0, sec_pkg::M_WR_MASK[i], 2'h0);
    end
    xa(PM, 1'b1, LH, 2'h0, ONES, 64'h0, 2'h0);
    xa(PM, 1'b0, LH, 2'h0, 64'h0, F0, 2'h0);
    xa(PM, 1'b1, LS, 2'h0, ONES, 64'h0, 2'h0);
    xa(PM, 1'b0, LS, 2'h0, 64'h0, 64'h7, 2'h0);
    $display("test write masks done");
  endtask : t_mwrite

  task automatic t_priv();
    xa(PS, 1'b0, LM, 2'h0, 64'h0, 64'h0, IL);
    xa(PM, 1'b0, LM, 2'h0, 64'h0, F0, 2'h0);
    xa(PS, 1'b0, LS, 2'h0, 64'h0, 64'h7, 2'h0);
    xa(PVS, 1'b0, LS, 2'h0, 64'h0, 64'h7, 2'h0);
    xa(PVU, 1'b0, LS, 2'h0, 64'h0, 64'h0, VI);
    xa(PU, 1'b0, LS, 2'h0, 64'h0, 64'h0, IL);
    xa(PVS, 1'b0, LH, 2'h0, 64'h0, 64'h0, VI);
    xa(PU, 1'b0, LH, 2'h0, 64'h0, 64'h0, IL);
    xa(PS, 1'b0, LH, 2'h0, 64'h0, F0, 2'h0);
    xa(PM, 1'b0, 2'h3, 2'h0, 64'h0, 64'h0, IL);
    xa(PM, 1'b0, LM, 2'h0, 64'h0, 64'h0, IL, 1'b1);
    xa(PM, 1'b1, LH, 2'h0, 64'h4000_0000_0000_0007, F0, 2'h0);
    xa(PVS, 1'b0, LS, 2'h0, 64'h0, 64'h0, VI);
    xa(PS, 1'b0, LS, 2'h0, 64'h0, 64'h7, 2'h0);
    xa(PM, 1'b1, LM, 2'h1, 64'h0, sec_pkg::M_WR_MASK[1], 2'h0);
    xa(PS, 1'b0, LS, 2'h1, 64'h0, 64'h0, IL);
    xa(PVS, 1'b0, LS, 2'h1, 64'h0, 64'h0, IL);
    xa(PS, 1'b0, LH, 2'h1, 64'h0, 64'h0, IL);
    xa(PM, 1'b1, LH, 2'h0, ONES, 64'h4000_0000_0000_0007, 2'h0);
    $display("test privilege gating done");
  endtask : t_priv

  task automatic t_chk();
    ck(PU, 2'h0, 6'h0, 2'h0);
    ck(PVU, 2'h0, 6'h0, 2'h0);
    xa(PM, 1'b1, LS, 2'h0, 64'h6, 64'h7, 2'h0);
    ck(PU, 2'h0, 6'h0, IL);
    ck(PS, 2'h0, 6'h0, 2'h0);
    ck(PVU, 2'h0, 6'h0, VI);
    ck(PM, 2'h1, 6'h5, 2'h0);
    ck(PS, 2'h1, 6'h5, IL);
    xa(PM, 1'b1, LH, 2'h0, 64'hC000_0000_0000_0005, F0, 2'h0);
    ck(PVS, 2'h0, 6'h1, VI);
    ck(PS, 2'h0, 6'h1, 2'h0);
    xa(PVS, 1'b0, LS, 2'h0, 64'h0, 64'h4, 2'h0);
    xa(PS, 1'b0, LS, 2'h0, 64'h0, 64'h6, 2'h0);
    $display("test state checks done");
  endtask : t_chk

  task automatic t_cascade();
    xa(PM, 1'b1, LM, 2'h0, 64'h8000_0000_0000_0003, F0, 2'h0);
    xa(PM, 1'b0, LH, 2'h0, 64'h0, 64'h8000_0000_0000_0001, 2'h0);
    xa(PM, 1'b0, LS, 2'h0, 64'h0, 64'h2, 2'h0);
    xa(PM, 1'b1, LH, 2'h0, ONES, 64'h8000_0000_0000_0001, 2'h0);
    xa(PM, 1'b0, LH, 2'h0, 64'h0, 64'h8000_0000_0000_0003, 2'h0);
    ck(PU, 2'h0, 6'h2, IL);
    $display("test cascade done");
  endtask : t_cascade

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Hang guard: a stalled run still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    $display("ERROR run_length expected done seen hang");
    wrap_up();
  end

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    srst = 1'b1;
    {chk_req, chk_index, chk_bit} = 9'h0;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    t_reset();
    t_mwrite();
    t_priv();
    t_chk();
    t_cascade();
    wrap_up();
  end
endmodule : sec_state_enable_tb

`default_nettype wire
